// ---- hw/sdli_dev.sv ----
// Converter end: shift register, transparent code register, chain output
//
// Contract
// - Shift data in on serial clock rise
// - Most significant bit first, least last
// - Strobe low: code register follows shift register
// - Strobe high: code register holds value
// - Chain output from twelfth shift stage
// - Chained devices share clock and load
// - Host shifts whole chain, then loads once
// - Host keeps serial clock within maximum
// - All ones code means full scale
// - Chain output changes on rising edge
`timescale 1ns/100ps
`include "sdli_regs.svh"
module sdli_dev #(
	parameter int WORD_BITS = `SDLI_WORD_BITS
) (
	// Clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 rst_b_i,
	// Link
	sdli_if.dev                       link,
	// Converter side
	output logic [WORD_BITS-1:0]      code_o,
	output logic                      full_scale_o
);
	////////////////////////////////////////////////////////////////////////
	logic [2:0]           sclk_s_r, sclk_s_nxt;
	logic [1:0]           din_s_r, din_s_nxt;
	logic [1:0]           ld_s_r, ld_s_nxt;
	logic [WORD_BITS-1:0] shreg_r, shreg_nxt;
	logic [WORD_BITS-1:0] code_r, code_nxt;
	logic                 fs_r, fs_nxt;
	logic                 rise;

	// Two-stage synchronisers; bit 2 of clock chain only feeds the edge detector
	always_comb
	begin
		sclk_s_nxt = {sclk_s_r[1:0], link.sclk};
		din_s_nxt  = {din_s_r[0], link.sdata};
		ld_s_nxt   = {ld_s_r[0], link.load_n};
	end
	assign rise = sclk_s_r[1] & ~sclk_s_r[2];

	// Shift on rise, new bit enters at LSB so first bit ends at MSB
	always_comb
	begin
		shreg_nxt = shreg_r;
		if (rise)
			shreg_nxt = {shreg_r[WORD_BITS-2:0], din_s_r[1]};
	end

	// Transparent while strobe low, holds once high; shift samples use the
	// updated value so the register tracks it in the same cycle, with no latency
	always_comb
	begin
		code_nxt = code_r;
		if (!ld_s_r[1])
			code_nxt = shreg_nxt;
		fs_nxt = (code_nxt == `SDLI_FULL_SCALE);
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sclk_s_r <= 3'h0;
			din_s_r  <= 2'h0;
			ld_s_r   <= 2'h3;
			shreg_r  <= '0;
			code_r   <= '0;
			fs_r     <= 1'b0;
		end
		else
		begin
			sclk_s_r <= sclk_s_nxt;
			din_s_r  <= din_s_nxt;
			ld_s_r   <= ld_s_nxt;
			shreg_r  <= shreg_nxt;
			code_r   <= code_nxt;
			fs_r     <= fs_nxt;
		end
	end

	// Outputs straight from flops; chain output follows last stage after rise
	assign link.sdout   = shreg_r[WORD_BITS-1];
	assign code_o       = code_r;
	assign full_scale_o = fs_r;
endmodule : sdli_dev

// ---- hw/sdli_host.sv ----
// Host end: serialises a chain of words and pulses the shared load strobe
`timescale 1ns/100ps
`include "sdli_regs.svh"
module sdli_host #(
	parameter int WORD_BITS = `SDLI_WORD_BITS,
	parameter int CHAIN     = 1,
	parameter int HALF_CYC  = `SDLI_HALF_CYC,
	parameter int LOAD_CYC  = `SDLI_LOAD_CYC
) (
	// Clock and reset
	input  wire logic                       mclk_i,
	input  wire logic                       rst_b_i,
	// Link
	sdli_if.host                            link,
	// User request
	input  wire logic                       start_i,
	input  wire logic [CHAIN*WORD_BITS-1:0] data_i,
	output logic                            busy_o,
	output logic                            done_o
);
	localparam int NB = CHAIN * WORD_BITS;
	////////////////////////////////////////////////////////////////////////
	sdli_pkg::sdli_host_st_t st_r, st_nxt;
	logic [NB-1:0]  sh_r, sh_nxt;
	logic [15:0]    bits_r, bits_nxt;
	logic [15:0]    tmr_r, tmr_nxt;
	logic           sclk_r, sclk_nxt;
	logic           ld_r, ld_nxt;
	logic           busy_r, busy_nxt;
	logic           done_r, done_nxt;

	// Data changes on falling edge; HALF_CYC is rounded up from the maximum
	// clocking rate, so the full period never beats the limit
	always_comb
	begin
		st_nxt   = st_r;
		sh_nxt   = sh_r;
		bits_nxt = bits_r;
		tmr_nxt  = tmr_r;
		sclk_nxt = sclk_r;
		ld_nxt   = ld_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		case (st_r)
			sdli_pkg::SDLI_IDLE:
				if (start_i)
				begin
					sh_nxt = data_i;              // whole chain sent
					bits_nxt = NB[15:0];
					tmr_nxt = HALF_CYC[15:0];
					busy_nxt = 1'b1;
					st_nxt = sdli_pkg::SDLI_SHIFT;
				end
			sdli_pkg::SDLI_SHIFT:
				if (tmr_r > 16'h1)
					tmr_nxt = tmr_r - 16'h1;
				else
				begin
					tmr_nxt = HALF_CYC[15:0];
					if (!sclk_r)
						sclk_nxt = 1'b1;
					else
					begin
						sclk_nxt = 1'b0;
						sh_nxt = {sh_r[NB-2:0], 1'b0};
						bits_nxt = bits_r - 16'h1;
						if (bits_r == 16'h1)
						begin
							ld_nxt = 1'b0;               // one shared strobe
							tmr_nxt = LOAD_CYC[15:0];
							st_nxt = sdli_pkg::SDLI_LOAD;
						end
					end
				end
			sdli_pkg::SDLI_LOAD:
				if (tmr_r > 16'h1)
					tmr_nxt = tmr_r - 16'h1;
				else
				begin
					ld_nxt = 1'b1;
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
					st_nxt = sdli_pkg::SDLI_IDLE;
				end
			default:
				st_nxt = sdli_pkg::SDLI_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_r   <= sdli_pkg::SDLI_IDLE;
			sh_r   <= '0;
			bits_r <= 16'h0;
			tmr_r  <= 16'h0;
			sclk_r <= 1'b0;
			ld_r   <= 1'b1;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			st_r   <= st_nxt;
			sh_r   <= sh_nxt;
			bits_r <= bits_nxt;
			tmr_r  <= tmr_nxt;
			sclk_r <= sclk_nxt;
			ld_r   <= ld_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	// MSB of the chain word presented first; shared clock and load lines
	assign link.sdata  = sh_r[NB-1];
	assign link.sclk   = sclk_r;
	assign link.load_n = ld_r;
	assign busy_o      = busy_r;
	assign done_o      = done_r;
endmodule : sdli_host

// ---- hw/sdli_if.sv ----
// Link wires between host controller and converter load logic
`timescale 1ns/100ps
interface sdli_if;
	logic sclk;
	logic sdata;
	logic load_n;
	logic sdout;
	modport host (output sclk, output sdata, output load_n, input sdout);
	modport dev  (input sclk, input sdata, input load_n, output sdout);
endinterface : sdli_if

// ---- hw/sdli_pkg.sv ----
// Types used by the host end of the load interface
package sdli_pkg;
	typedef enum logic [1:0] {
		SDLI_IDLE  = 2'h0,
		SDLI_SHIFT = 2'h1,
		SDLI_LOAD  = 2'h3
	} sdli_host_st_t;
endpackage : sdli_pkg

// ---- hw/sdli_regs.svh ----
// Constants for the serial converter load interface
`ifndef SDLI_REGS_SVH
`define SDLI_REGS_SVH
`define SDLI_WORD_BITS     12
`define SDLI_FULL_SCALE    12'hFFF
`define SDLI_CLK_PERIOD_NS 50
`define SDLI_FMAX_KHZ      1400
`define SDLI_MIN_HALF_NS   350
`define SDLI_HALF_CYC      ((1000000 + 2 * `SDLI_FMAX_KHZ * `SDLI_CLK_PERIOD_NS - 1) / (2 * `SDLI_FMAX_KHZ * `SDLI_CLK_PERIOD_NS))
`define SDLI_LOAD_MIN_NS   150
`define SDLI_LOAD_CYC      ((`SDLI_LOAD_MIN_NS + `SDLI_CLK_PERIOD_NS - 1) / `SDLI_CLK_PERIOD_NS)
`endif

// ---- verification/sdli_props.sv ----
// Link checks for the converter load interface
`timescale 1ns/100ps
module sdli_props (
	// Clock, reset and link
	input wire logic        mclk_i,
	input wire logic        rst_b_i,
	input wire logic        sclk,
	input wire logic        sdata,
	input wire logic        load_n,
	input wire logic        sdout,
	// Converter side
	input wire logic [11:0] code_o,
	input wire logic        full_scale_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////
	// Strobe is exactly three cycles low, then high again
	sequence s_ld; !load_n [*3] ##1 load_n; endsequence
	property p_hi; $rose(sclk) |-> sclk [*8]; endproperty
	a_hi: assert property (p_hi) else $error("clock high too short");
	property p_lo; $fell(sclk) |-> !sclk [*8]; endproperty
	a_lo: assert property (p_lo) else $error("clock low too short");
	property p_ld; $fell(load_n) |-> s_ld; endproperty
	a_ld: assert property (p_ld) else $error("bad strobe");
	property p_ldclk; !load_n |-> !sclk; endproperty
	a_ldclk: assert property (p_ldclk) else $error("clock during strobe");
	// Margin covers the two-flop sampling lag of the strobe
	property p_hold; load_n [*8] |-> $stable(code_o); endproperty
	a_hold: assert property (p_hold) else $error("code moved");
	property p_fs; $stable(code_o) |-> full_scale_o == (code_o == 12'hFFF); endproperty
	a_fs: assert property (p_fs) else $error("bad full scale");
	property p_dout; $changed(sdout) |-> $past(sclk, 3); endproperty
	a_dout: assert property (p_dout) else $error("chain out off edge");
	property p_sd; sclk |-> $stable(sdata); endproperty
	a_sd: assert property (p_sd) else $error("data moved");
endmodule : sdli_props

// ---- verification/serial_dac_load_interface_tb.sv ----
// Bench: host driving a chain of two converter ends
`timescale 1ns/100ps
module serial_dac_load_interface_tb;
	logic        mclk_i  = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        start_i = 1'b0;
	logic [23:0] data_i  = 24'h0;
	logic [11:0] code0;
	logic [11:0] code1;
	logic        fs0;
	logic        fs1;
	logic        busy_o;
	logic        done_o;
	int          n_fail = 0;
	int          comparisons = 0;
	sdli_if la();
	sdli_if lb();
	// Shared clock and strobe, first end feeds the second
	assign lb.sclk   = la.sclk;
	assign lb.load_n = la.load_n;
	assign lb.sdata  = la.sdout;
	always #25 mclk_i = ~mclk_i;
	sdli_host #(.CHAIN(2)) sdli_host_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(la.host),
		.start_i(start_i), .data_i(data_i), .busy_o(busy_o), .done_o(done_o));
	sdli_dev sdli_dev_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(la.dev), .code_o(code0), .full_scale_o(fs0));
	sdli_dev sdli_dev_inst_b (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(lb.dev), .code_o(code1), .full_scale_o(fs1));
	sdli_props sdli_props_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sclk(la.sclk), .sdata(la.sdata),
		.load_n(la.load_n), .sdout(la.sdout), .code_o(code0), .full_scale_o(fs0));
	////////////////////////////////
	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		comparisons++;
		if (s !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic summarize;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	// One chain transfer, then compare both ends with a bit-serial model
	task automatic xfer(input logic [23:0] d);
		int i;
		bit [23:0] sr;
		@(posedge mclk_i);
		start_i <= 1'b1;
		data_i  <= d;
		@(posedge mclk_i);
		start_i <= 1'b0;
		for (i = 0; i < 900 && done_o !== 1'b1; i++)
		begin
			@(posedge mclk_i);
			#1;
		end
		if (i == 900)
		begin
			n_fail++;
			summarize();
		end
		for (i = 23; i >= 0; i--)
			sr = {sr[22:0], d[i]};
		repeat (4) @(posedge mclk_i);
		chk(code0, sr[11:0]);
		chk(code1, sr[23:12]);
		chk({11'h0, fs1}, {11'h0, sr[23:12] == 12'hFFF});
		chk({11'h0, fs0}, {11'h0, sr[11:0] == 12'hFFF});
		chk({11'h0, busy_o}, 12'h000);
	endtask : xfer
	////////////////////////////////
	initial
	begin
		void'($urandom(32'h84E9EF2B));
		repeat (3) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		xfer(24'hFFF000);
		xfer(24'h000FFF);
		repeat (4) xfer(24'($urandom));
		summarize();
	end
endmodule : serial_dac_load_interface_tb
